// ===== hw/wei_map.svh
// register offsets, field positions and reset values of the wakeup edge and enable block
`ifndef WEI_MAP_SVH
`define WEI_MAP_SVH

// byte offsets on the register bus
`define WEI_OFS_EDGE      5'h00
`define WEI_OFS_ENABLE    5'h04
`define WEI_OFS_WFLAG     5'h08
`define WEI_OFS_DTFLAG    5'h0c
`define WEI_OFS_STATUS    5'h10
`define WEI_OFS_MASK      5'h14

// reserved bits that always read as one
`define WEI_EDGE_RSVD     8'hc0
`define WEI_ENABLE_RSVD   8'h10
`define WEI_WFLAG_RSVD    8'hc0
`define WEI_DTFLAG_RSVD   8'h7f

// reset values of the writable fields
`define WEI_EDGE_RST      6'h00
`define WEI_ENABLE_RST    8'h00
`define WEI_STATUS_RST    8'h00

// field positions in the enable register
`define WEI_EN_DT         7
`define WEI_EN_TA         6
`define WEI_EN_WAKE       5
`define WEI_EN_WMASK      8'hef

// field positions in the event status register
`define WEI_ST_DT         6
`define WEI_ST_TRIG       7

// shared wakeup pin that also feeds the converter trigger
`define WEI_TRIG_PIN      5

`endif

// ===== hw/wei_pkg.sv
// types of the wakeup edge and enable block
package wei_pkg;
    typedef enum logic {WEI_BUS_IDLE, WEI_BUS_ANSWER} wei_bus_t;
    typedef logic [7:0] wei_byte_t;
endpackage : wei_pkg

// ===== hw/wei_top.sv
// wakeup edge select, interrupt enable and request gating with an avalon-mm slave
// Function
// R1: bits 7 and 6 of the wakeup edge select register read as one and ignore writes.
// R2: bits 5 to 0 of the edge select pick falling (0) or rising (1) edge per wakeup pin, reset 0.
// R3: the edge chosen for wakeup pin 5 also applies to the shared converter trigger input.
// R4: enable bit 7 passes the direct transition request to the cpu, reset 0.
// R5: enable bit 6 passes the timer overflow request, reset 0.
// R6: enable bit 5 is one common enable for all six wakeup requests, reset 0.
// R7: enable bit 4 reads as one and ignores writes.
// R8: enable bits 3 to 0 pass the four external pin requests each, reset 0.
// R9: a request colliding with a clear of its enable or flag while unmasked is still taken.
// R10: software should clear enables and flags only while the cpu mask bit is one.
// R11: a wakeup flag sets on the selected edge of an interrupt pin and clears only by writing 0.
// R12: the direct transition flag sets on a direct transition with control on, clears by 0.
// R13: while the cpu mask bit is one all maskable requests are held off.
// R14: each request is flag and enable, registered so it stands a full clock before use.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wei_map.svh"

module wei_top
    import wei_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [5:0]  wake_pin,
    input  wire logic [5:0]  wake_pin_irq_mode,
    input  wire logic        sleep_direct_transition,
    input  wire logic        direct_transition_control,
    input  wire logic        timer_flag_in,
    input  wire logic [3:0]  ext_flag_in,
    input  wire logic        cpu_mask,
    output logic             dt_req,
    output logic             ta_req,
    output logic             wake_req,
    output logic [3:0]       ext_req,
    output logic             converter_trigger_out,
    output logic             irq
);

    wei_bus_t    bus_r;
    logic [31:0] readdata_r;
    logic [5:0]  edge_r;
    wei_byte_t   enable_r;
    wei_byte_t   coll_r;
    logic [5:0]  wflag_r;
    logic        dtflag_r;
    wei_byte_t   status_r;
    wei_byte_t   mask_r;
    logic [5:0]  prev_r;
    logic        started_r;
    logic        dt_req_r;
    logic        ta_req_r;
    logic        wake_req_r;
    logic [3:0]  ext_req_r;
    logic        trig_r;
    logic        irq_r;

    logic        acc;
    logic        wr_acc;
    logic        wr_lane;
    logic [5:0]  det_rise;
    logic [5:0]  det_fall;
    logic [5:0]  det_sel;
    logic [5:0]  wake_set;
    logic        dt_set;
    wei_byte_t   pending;
    wei_byte_t   event_vec;
    wei_byte_t   rd_nxt;

    // an access completes at the edge where waitrequest is low
    assign acc     = (read || write) && (bus_r == WEI_BUS_ANSWER);
    assign wr_acc  = acc && write;
    assign wr_lane = wr_acc && byteenable[0];

    // waitrequest is high by default and drops for one cycle per access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_r <= WEI_BUS_IDLE;
        end else begin
            case (bus_r)
                WEI_BUS_IDLE: begin
                    if (read || write) begin
                        bus_r <= WEI_BUS_ANSWER;
                    end
                end
                WEI_BUS_ANSWER: bus_r <= WEI_BUS_IDLE;
                default:        bus_r <= WEI_BUS_IDLE;
            endcase
        end
    end

    // read mux, reserved bits forced to one, unmapped offsets read zero
    always_comb begin
        rd_nxt = 8'h00;
        case (address)
            `WEI_OFS_EDGE:   rd_nxt = `WEI_EDGE_RSVD | {2'h0, edge_r};                 // R1
            `WEI_OFS_ENABLE: rd_nxt = `WEI_ENABLE_RSVD | enable_r;                     // R7
            `WEI_OFS_WFLAG:  rd_nxt = `WEI_WFLAG_RSVD | {2'h0, wflag_r};
            `WEI_OFS_DTFLAG: rd_nxt = `WEI_DTFLAG_RSVD | {dtflag_r, 7'h00};
            `WEI_OFS_STATUS: rd_nxt = status_r;
            `WEI_OFS_MASK:   rd_nxt = mask_r;
            default:         rd_nxt = 8'h00;
        endcase
    end

    // read data is loaded while the request waits, so it stands at the answer edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && bus_r == WEI_BUS_IDLE) begin
            readdata_r <= {24'h00_0000, rd_nxt};
        end
    end

    // edge select: only the low six bits are stored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_r <= `WEI_EDGE_RST;                                                   // R2
        end else if (wr_lane && address == `WEI_OFS_EDGE) begin
            edge_r <= writedata[5:0];                                                  // R1 R2
        end
    end

    // enable register; bit 4 is never stored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_r <= `WEI_ENABLE_RST;
        end else if (wr_lane && address == `WEI_OFS_ENABLE) begin
            enable_r <= writedata[7:0] & `WEI_EN_WMASK;                                // R7
        end
    end

    // pending sources in enable layout
    assign pending = {dtflag_r, timer_flag_in, |wflag_r, 1'b0, ext_flag_in};

    // a clear of an enable that meets a pending request while unmasked keeps it alive
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            coll_r <= 8'h00;
        end else if (wr_lane && address == `WEI_OFS_ENABLE && !cpu_mask) begin
            coll_r <= (coll_r | (enable_r & ~writedata[7:0] & pending)) & pending;     // R9
        end else begin
            coll_r <= coll_r & pending;
        end
    end

    // pin edge detection, idle for the first cycle after reset
    assign det_rise = wake_pin & ~prev_r;
    assign det_fall = ~wake_pin & prev_r;
    assign det_sel  = started_r ? ((edge_r & det_rise) | (~edge_r & det_fall)) : 6'h00;
    assign wake_set = det_sel & wake_pin_irq_mode;
    assign dt_set   = sleep_direct_transition && direct_transition_control;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_r    <= 6'h00;
            started_r <= 1'b0;
        end else begin
            prev_r    <= wake_pin;
            started_r <= 1'b1;
        end
    end

    // wakeup flags: writing 0 clears, a same-cycle edge wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wflag_r <= 6'h00;
        end else if (wr_lane && address == `WEI_OFS_WFLAG) begin
            wflag_r <= (wflag_r & writedata[5:0]) | wake_set;                          // R11 R9
        end else begin
            wflag_r <= wflag_r | wake_set;                                             // R11
        end
    end

    // direct transition flag: writing 0 clears, a same-cycle set wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dtflag_r <= 1'b0;
        end else if (wr_lane && address == `WEI_OFS_DTFLAG) begin
            dtflag_r <= (dtflag_r && writedata[7]) || dt_set;                          // R12 R9
        end else begin
            dtflag_r <= dtflag_r || dt_set;                                            // R12
        end
    end

    // converter trigger follows the edge chosen for the shared pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= det_sel[`WEI_TRIG_PIN];                                          // R3
        end
    end

    // gated requests to the cpu, registered so they stand a full clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dt_req_r   <= 1'b0;
            ta_req_r   <= 1'b0;
            wake_req_r <= 1'b0;
            ext_req_r  <= 4'h0;
        end else begin
            dt_req_r   <= pending[`WEI_EN_DT] && !cpu_mask                             // R14 R13
                          && (enable_r[`WEI_EN_DT] || coll_r[`WEI_EN_DT]);             // R4
            ta_req_r   <= pending[`WEI_EN_TA] && !cpu_mask
                          && (enable_r[`WEI_EN_TA] || coll_r[`WEI_EN_TA]);             // R5
            wake_req_r <= pending[`WEI_EN_WAKE] && !cpu_mask
                          && (enable_r[`WEI_EN_WAKE] || coll_r[`WEI_EN_WAKE]);         // R6
            ext_req_r  <= ext_flag_in & (enable_r[3:0] | coll_r[3:0])
                          & {4{!cpu_mask}};                                            // R8
        end
    end

    // event status: sticky, write one to clear, a new event wins
    assign event_vec = {trig_r, dt_set, wake_set};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_r <= `WEI_STATUS_RST;
        end else if (wr_lane && address == `WEI_OFS_STATUS) begin
            status_r <= (status_r & ~writedata[7:0]) | event_vec;
        end else begin
            status_r <= status_r | event_vec;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_r <= `WEI_STATUS_RST;
        end else if (wr_lane && address == `WEI_OFS_MASK) begin
            mask_r <= writedata[7:0];
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    // outputs straight from flip-flops, except waitrequest, which is decoded from the bus state
    assign readdata              = readdata_r;
    assign waitrequest           = (bus_r == WEI_BUS_IDLE);
    assign dt_req                = dt_req_r;
    assign ta_req                = ta_req_r;
    assign wake_req              = wake_req_r;
    assign ext_req               = ext_req_r;
    assign converter_trigger_out = trig_r;
    assign irq                   = irq_r;

    // checks on register behaviour and request gating
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    edge_rsvd_read_a: assert property ( // R1
        (acc && read && address == `WEI_OFS_EDGE) |-> (readdata[7:6] == 2'b11))
        else $error("edge select reserved bits did not read one");

    edge_write_a: assert property ( // R2
        (wr_lane && address == `WEI_OFS_EDGE) |=> (edge_r == $past(writedata[5:0])))
        else $error("edge select field not written");

    trig_edge_a: assert property ( // R3
        started_r && (edge_r[5] ? det_rise[5] : det_fall[5]) |=> converter_trigger_out)
        else $error("converter trigger missed the selected edge");

    dt_gate_a: assert property ( // R4
        dt_req |-> $past(enable_r[7] || coll_r[7]) && $past(dtflag_r))
        else $error("direct transition request without enable");

    ta_gate_a: assert property ( // R5
        (timer_flag_in && enable_r[6] && !cpu_mask) |=> ta_req)
        else $error("timer request not forwarded");

    wake_gate_a: assert property ( // R6
        ((|wflag_r) && enable_r[5] && !cpu_mask) |=> wake_req)
        else $error("wakeup request not forwarded");

    en_rsvd_read_a: assert property ( // R7
        (acc && read && address == `WEI_OFS_ENABLE) |-> readdata[4] && !enable_r[4])
        else $error("enable reserved bit wrong");

    ext_gate_a: assert property ( // R8
        ext_req[0] |-> $past(ext_flag_in[0] && (enable_r[0] || coll_r[0])))
        else $error("external request without enable");

    collide_keep_a: assert property ( // R9
        (wr_lane && address == `WEI_OFS_ENABLE && !cpu_mask && enable_r[0]
         && !writedata[0] && ext_flag_in[0])
        |=> ##1 (ext_req[0] || $past(cpu_mask) || !$past(ext_flag_in[0])))
        else $error("colliding request lost");

    wake_set_a: assert property ( // R11
        (|wake_set) |=> ((wflag_r & $past(wake_set)) == $past(wake_set)))
        else $error("wakeup flag not set on edge");

    wflag_hold_a: assert property ( // R11
        !(wr_lane && address == `WEI_OFS_WFLAG)
        |=> ((wflag_r & $past(wflag_r)) == $past(wflag_r)))
        else $error("wakeup flag dropped without a write");

    dt_flag_a: assert property ( // R12
        dt_set |=> dtflag_r)
        else $error("direct transition flag not set");

    mask_hold_a: assert property ( // R13
        cpu_mask |=> !(dt_req || ta_req || wake_req || (|ext_req)))
        else $error("request passed while masked");

    answer_time_a: assert property ( // bus timing
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("access not answered in one cycle");

    req_form_a: assert property ( // R14
        ta_req == $past(timer_flag_in && (enable_r[6] || coll_r[6]) && !cpu_mask))
        else $error("timer request not formed from flag and enable");

    dt_req_cov: cover property (dt_set ##[1:4] dt_req);
    wake_req_cov: cover property (wake_set[5] ##1 converter_trigger_out ##1 wake_req);
    collide_cov: cover property ((coll_r != 8'h00) ##1 (|ext_req));
    irq_cov: cover property ($rose(irq));

endmodule : wei_top
`default_nettype wire

// ===== testbench/wei_cpu_model.sv
// cpu core stand-in: holds the interrupt mask and takes forwarded requests
`timescale 1ns/1ps
`default_nettype none

module wei_cpu_model (
    input  wire logic       sys_clk,
    input  wire logic       mask_set,
    input  wire logic [6:0] reqs,
    output logic            cpu_mask,
    output logic [7:0]      taken_cnt
);
    // mask starts set, as after a core reset
    logic       mask_q  = 1'b1;
    logic [7:0] taken_q = 8'h00;
    // software sets the mask before clearing enables or flags, except in the collision test that clears enables while unmasked
    always @(posedge sys_clk) mask_q <= mask_set;
    // a request seen while unmasked is taken
    always @(negedge sys_clk) if (!mask_q && |reqs) taken_q <= taken_q + 8'h01;
    assign cpu_mask  = mask_q;
    assign taken_cnt = taken_q;
endmodule : wei_cpu_model

`default_nettype wire

// ===== testbench/wei_top_test.sv
// self-checking bench for the wakeup edge and enable block
`timescale 1ns/1ps
`default_nettype none
`include "wei_map.svh"

module wei_top_test;
    logic        sys_clk, rst, read, write, waitrequest, sleep_dt, dt_ctrl, timer_flag_in;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rdata;
    logic [3:0]  ext_flag_in, ext_req;
    logic [5:0]  wake_pin, irq_mode;
    logic        cpu_mask, mask_want, dt_req, ta_req, wake_req, trig_out, irq;
    logic [7:0]  taken_cnt, taken0;
    logic [7:0]  tbl [6] = '{8'h40, 8'h01, 8'h02, 8'h04, 8'h08, 8'h4f};
    int          err_count = 0, n_compared = 0, cyc = 0, trig_cnt = 0;

    wei_top DUT (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
        .waitrequest(waitrequest), .wake_pin(wake_pin), .wake_pin_irq_mode(irq_mode),
        .sleep_direct_transition(sleep_dt), .direct_transition_control(dt_ctrl),
        .timer_flag_in(timer_flag_in), .ext_flag_in(ext_flag_in), .cpu_mask(cpu_mask),
        .dt_req(dt_req), .ta_req(ta_req), .wake_req(wake_req), .ext_req(ext_req),
        .converter_trigger_out(trig_out), .irq(irq));

    wei_cpu_model cpu (.sys_clk(sys_clk), .mask_set(mask_want),
        .reqs({dt_req, ta_req, wake_req, ext_req}), .cpu_mask(cpu_mask), .taken_cnt(taken_cnt));

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // converter trigger pulses counted where they are settled
    always @(negedge sys_clk) if (trig_out === 1'b1) trig_cnt++;

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdata, {24'h0, e});
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic setmask(input logic m);
        @(posedge sys_clk) mask_want <= m;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : setmask

    // main sequence
    initial begin
        address = 5'h00; read = 1'b0; write = 1'b0; writedata = 32'h0;
        wake_pin = 6'h1f; irq_mode = 6'h3f; sleep_dt = 1'b0; dt_ctrl = 1'b1;
        timer_flag_in = 1'b0; ext_flag_in = 4'h0; mask_want = 1'b0; rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`WEI_OFS_EDGE, 8'hc0);
        rd(`WEI_OFS_ENABLE, 8'h10);
        rd(5'h18, 8'h00);
        bus(1'b1, `WEI_OFS_EDGE, 8'h3f);
        rd(`WEI_OFS_EDGE, 8'hff);
        bus(1'b1, `WEI_OFS_EDGE, 8'h20);
        rd(`WEI_OFS_EDGE, 8'he0);
        bus(1'b1, `WEI_OFS_ENABLE, 8'h20);
        rd(`WEI_OFS_ENABLE, 8'h30);
        bus(1'b1, `WEI_OFS_MASK, 8'h01);
        // falling edge on pin 0 with the common enable on
        @(posedge sys_clk) wake_pin[0] <= 1'b0;
        settle();
        chk(32'(wake_req), 32'h1);
        chk(32'(irq), 32'h1);
        rd(`WEI_OFS_WFLAG, 8'hc1);
        setmask(1'b1);
        chk(32'(wake_req), 32'h0);
        bus(1'b1, `WEI_OFS_WFLAG, 8'h00);
        rd(`WEI_OFS_WFLAG, 8'hc0);
        bus(1'b1, `WEI_OFS_STATUS, 8'h01);
        settle();
        chk(32'(irq), 32'h0);
        // pin not in interrupt mode sets no flag
        @(posedge sys_clk) irq_mode[0] <= 1'b0;
        @(posedge sys_clk) wake_pin[0] <= 1'b1;
        settle();
        @(posedge sys_clk) wake_pin[0] <= 1'b0;
        rd(`WEI_OFS_WFLAG, 8'hc0);
        // rising edge on the shared pin 5 also fires the converter trigger
        setmask(1'b0);
        @(posedge sys_clk) wake_pin[5] <= 1'b1;
        settle();
        chk(32'(trig_cnt), 32'h1);
        chk(32'(wake_req), 32'h1);
        rd(`WEI_OFS_STATUS, 8'ha0);
        @(posedge sys_clk) wake_pin[5] <= 1'b0;
        settle();
        chk(32'(trig_cnt), 32'h1);
        setmask(1'b1);
        bus(1'b1, `WEI_OFS_WFLAG, 8'h00);
        bus(1'b1, `WEI_OFS_STATUS, 8'hff);
        // per-source enables, changed only under the mask
        @(posedge sys_clk) timer_flag_in <= 1'b1;
        @(posedge sys_clk) ext_flag_in <= 4'hf;
        foreach (tbl[i]) begin
            bus(1'b1, `WEI_OFS_ENABLE, tbl[i]);
            setmask(1'b0);
            chk(32'({ta_req, ext_req}), 32'({tbl[i][6], tbl[i][3:0]}));
            setmask(1'b1);
        end
        chk(32'({ta_req, ext_req}), 32'h0);
        // enables cleared while unmasked and requests pending
        setmask(1'b0);
        bus(1'b1, `WEI_OFS_ENABLE, 8'h00);
        settle();
        chk(32'({ta_req, ext_req}), 32'h1f);
        taken0 = taken_cnt;
        @(negedge sys_clk);
        chk(32'(taken_cnt != taken0), 32'h1);
        @(posedge sys_clk) timer_flag_in <= 1'b0;
        @(posedge sys_clk) ext_flag_in <= 4'h0;
        settle();
        chk(32'({ta_req, ext_req}), 32'h0);
        // direct transition flag and its enable
        setmask(1'b1);
        bus(1'b1, `WEI_OFS_ENABLE, 8'h80);
        @(posedge sys_clk) sleep_dt <= 1'b1;
        @(posedge sys_clk) sleep_dt <= 1'b0;
        rd(`WEI_OFS_DTFLAG, 8'hff);
        rd(`WEI_OFS_STATUS, 8'h40);
        setmask(1'b0);
        chk(32'(dt_req), 32'h1);
        setmask(1'b1);
        bus(1'b1, `WEI_OFS_DTFLAG, 8'h00);
        rd(`WEI_OFS_DTFLAG, 8'h7f);
        @(posedge sys_clk) dt_ctrl <= 1'b0;
        @(posedge sys_clk) sleep_dt <= 1'b1;
        @(posedge sys_clk) sleep_dt <= 1'b0;
        rd(`WEI_OFS_DTFLAG, 8'h7f);
        stop_test();
    end
endmodule : wei_top_test

`default_nettype wire
